// ===== fotl_load_model.sv
// fotl_load_model: external equipment sensing the output contacts
`timescale 1ns/1ps
module fotl_load_model
(
  input  wire logic       sys_clk,
  input  wire logic       first_relay,
  input  wire logic       open_collector_output,
  input  wire logic       second_relay,
  input  wire logic [2:0] exp_out,
  output logic      [5:0] closed,
  output int              n_switch
);
  logic [5:0] last_q = 6'h00;
  int         n_q    = 0;

  // sensed contact closure, bit 0 first relay
  assign closed   = {exp_out, second_relay, open_collector_output, first_relay};
  assign n_switch = n_q;

  // counts contact movements seen by the load
  always @(posedge sys_clk)
  begin
    if (closed != last_q)
      n_q <= n_q + 1;
    last_q <= closed;
  end
endmodule

// ===== fotl_pkg.sv
// fotl_pkg: constants, register map and types of the fault and output terminal block
package fotl_pkg;

  // bus geometry
  localparam int          APB_DW            = 32;
  localparam int          APB_AW            = 8;

  // register byte offsets
  localparam logic [7:0]  OFF_TRIP_MODE     = 8'h00;
  localparam logic [7:0]  OFF_FUNC_BASE     = 8'h04;
  localparam logic [7:0]  OFF_GEN_ON_DLY    = 8'h08;
  localparam logic [7:0]  OFF_GEN_OFF_DLY   = 8'h0c;
  localparam logic [7:0]  OFF_TRIP_ON_DLY   = 8'h10;
  localparam logic [7:0]  OFF_TRIP_OFF_DLY  = 8'h14;
  localparam logic [7:0]  OFF_POLARITY      = 8'h18;
  localparam logic [7:0]  OFF_INT_STATUS    = 8'h1c;
  localparam logic [7:0]  OFF_INT_MASK      = 8'h20;
  localparam logic [7:0]  OFF_OUT_STATE     = 8'h24;
  localparam logic [7:0]  OFF_FUNC_EXP      = 8'h28;

  // trip indication mask fields
  localparam int          TM_W              = 3;
  localparam int          TM_LOW_VOLT_BIT   = 0;
  localparam int          TM_OTHER_BIT      = 1;
  localparam int          TM_RESTART_BIT    = 2;
  localparam logic [2:0]  TRIP_MODE_RST     = 3'h2;

  // output channels, polarity bit order starts at bit 0
  localparam int          NUM_BASE          = 3;
  localparam int          NUM_CH            = 6;
  localparam int          CH_FIRST_RELAY         = 0;
  localparam int          CH_OPEN_COLL      = 1;
  localparam int          CH_RELAY2         = 2;
  localparam logic [5:0]  POLARITY_RST      = 6'h00;

  // function selection fields, one byte per channel
  localparam int          FUNC_W            = 6;
  localparam int          FUNC_STRIDE       = 8;
  localparam logic [5:0]  FUNC_TRIP         = 6'd28;
  localparam logic [5:0]  FUNC_FIRST_RELAY_RST   = 6'd29;
  localparam logic [5:0]  FUNC_RELAY2_RST   = 6'd14;
  localparam logic [5:0]  FUNC_OPEN_C_RST   = 6'd1;
  localparam logic [5:0]  FUNC_EXP_RST      = 6'd0;

  // delays in 10 ms steps
  localparam int          DLY_W             = 16;
  localparam logic [15:0] DLY_RST           = 16'h0000;
  localparam int          TICK_MS           = 10;
  localparam int          CLK_MHZ           = 100;
  localparam int          TICK_CYC          = TICK_MS * 1000 * CLK_MHZ;

  // interrupt events
  localparam int          EV_W              = 3;
  localparam int          EV_FAULT_ON       = 0;
  localparam int          EV_FAULT_OFF      = 1;
  localparam int          EV_OUT_CHANGE     = 2;
  localparam logic [2:0]  INT_MASK_RST      = 3'h0;

  typedef struct packed {
    logic restart_fail;
    logic other;
    logic low_voltage;
  } fotl_trip_t;

  typedef enum logic {APB_IDLE, APB_ACK} fotl_apb_st_t;

endpackage

// ===== fotl_terminal.sv
// fotl_terminal: trip indication, delayed output terminals, polarity, APB registers
`timescale 1ns/1ps
module fotl_terminal
#(
  parameter int TICK_CYCLES = fotl_pkg::TICK_CYC
)
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire fotl_pkg::fotl_trip_t trip_in,
  input  wire logic [5:0]          cond_in,
  input  wire logic                exp_fitted,
  output logic                     first_relay,
  output logic                     open_collector_output,
  output logic                     second_relay,
  output logic      [2:0]          exp_out,
  output logic                     irq
);
  import fotl_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, OFF_TRIP_MODE) || hit(a, OFF_FUNC_BASE) || hit(a, OFF_GEN_ON_DLY) ||
           hit(a, OFF_GEN_OFF_DLY) || hit(a, OFF_TRIP_ON_DLY) || hit(a, OFF_TRIP_OFF_DLY) ||
           hit(a, OFF_POLARITY) || hit(a, OFF_INT_STATUS) || hit(a, OFF_INT_MASK) ||
           hit(a, OFF_OUT_STATE) || hit(a, OFF_FUNC_EXP);
  endfunction

  // two-stage synchronisers for pin inputs
  fotl_trip_t          trip_meta_q;
  fotl_trip_t          trip_s_q;
  logic [NUM_CH-1:0]   cond_meta_q;
  logic [NUM_CH-1:0]   cond_s_q;
  logic                exp_meta_q;
  logic                exp_s_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      trip_meta_q <= '0;
      trip_s_q    <= '0;
      cond_meta_q <= '0;
      cond_s_q    <= '0;
      exp_meta_q  <= 1'b0;
      exp_s_q     <= 1'b0;
    end
    else
    begin
      trip_meta_q <= trip_in;
      trip_s_q    <= trip_meta_q;
      cond_meta_q <= cond_in;
      cond_s_q    <= cond_meta_q;
      exp_meta_q  <= exp_fitted;
      exp_s_q     <= exp_meta_q;
    end
  end

  // bus and configuration state
  fotl_apb_st_t        st_q, st_d;
  logic                pready_q, pready_d;
  logic                pslverr_q, pslverr_d;
  logic [31:0]         prdata_q, prdata_d;
  logic [TM_W-1:0]     trip_mode_q, trip_mode_d;
  logic [FUNC_W-1:0]   func_q [NUM_CH];
  logic [FUNC_W-1:0]   func_d [NUM_CH];
  logic [DLY_W-1:0]    gon_q, gon_d, goff_q, goff_d, ton_q, ton_d, toff_q, toff_d;
  logic [NUM_CH-1:0]   pol_q, pol_d;
  logic [EV_W-1:0]     sts_q, sts_d, mask_q, mask_d;
  logic                irq_q, irq_d;
  logic [NUM_CH-1:0]   ch_st_q, ch_st_d;
  logic [DLY_W-1:0]    cnt_q [NUM_CH];
  logic [DLY_W-1:0]    cnt_d [NUM_CH];
  logic [NUM_CH-1:0]   pin_q, pin_d;
  logic [31:0]         tick_cnt_q, tick_cnt_d;
  logic                tick_q, tick_d;
  logic                fault_ind, fault_ind_q;
  logic                wr_fire;
  logic [31:0]         rd_value;
  logic [EV_W-1:0]     ev;

  // trip indication from masked trip types
  always_comb
  begin
    fault_ind = 1'b0;
    if (trip_mode_q[TM_LOW_VOLT_BIT] && trip_s_q.low_voltage)
      fault_ind = 1'b1;
    if (trip_mode_q[TM_OTHER_BIT] && trip_s_q.other)
      fault_ind = 1'b1;
    if (trip_mode_q[TM_RESTART_BIT] && trip_s_q.restart_fail)
      fault_ind = 1'b1;
  end

  assign wr_fire = (st_q == APB_ACK) && psel && penable && pwrite && !pslverr_q;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (paddr)
      OFF_TRIP_MODE:    rd_value[TM_W-1:0] = trip_mode_q;
      OFF_GEN_ON_DLY:   rd_value[DLY_W-1:0] = gon_q;
      OFF_GEN_OFF_DLY:  rd_value[DLY_W-1:0] = goff_q;
      OFF_TRIP_ON_DLY:  rd_value[DLY_W-1:0] = ton_q;
      OFF_TRIP_OFF_DLY: rd_value[DLY_W-1:0] = toff_q;
      OFF_POLARITY:     rd_value[NUM_CH-1:0] = exp_s_q ? pol_q : {3'h0, pol_q[NUM_BASE-1:0]};
      OFF_INT_STATUS:   rd_value[EV_W-1:0] = sts_q;
      OFF_INT_MASK:     rd_value[EV_W-1:0] = mask_q;
      OFF_OUT_STATE:    rd_value[NUM_CH:0] = {fault_ind_q, ch_st_q};
      default:          rd_value = 32'h0000_0000;
    endcase
    for (int i = 0; i < NUM_BASE; i++)
    begin
      if (hit(paddr, OFF_FUNC_BASE))
        rd_value[i*FUNC_STRIDE +: FUNC_W] = func_q[i];
      if (hit(paddr, OFF_FUNC_EXP))
        rd_value[i*FUNC_STRIDE +: FUNC_W] = func_q[i+NUM_BASE];
    end
  end

  // apb answer one cycle into the access phase
  always_comb
  begin
    st_d      = st_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    case (st_q)
      APB_IDLE:
        if (psel && penable)
        begin
          st_d      = APB_ACK;
          pready_d  = 1'b1;
          pslverr_d = !mapped(paddr);
          prdata_d  = mapped(paddr) ? rd_value : 32'h0000_0000;
        end
      APB_ACK:
        st_d = APB_IDLE;
      default:
        st_d = APB_IDLE;
    endcase
  end

  // register writes and sticky status
  always_comb
  begin
    trip_mode_d = trip_mode_q;
    gon_d       = gon_q;
    goff_d      = goff_q;
    ton_d       = ton_q;
    toff_d      = toff_q;
    pol_d       = pol_q;
    mask_d      = mask_q;
    func_d      = func_q;
    if (wr_fire && hit(paddr, OFF_TRIP_MODE))
      trip_mode_d = pwdata[TM_W-1:0];
    if (wr_fire && hit(paddr, OFF_GEN_ON_DLY))
      gon_d = pwdata[DLY_W-1:0];
    if (wr_fire && hit(paddr, OFF_GEN_OFF_DLY))
      goff_d = pwdata[DLY_W-1:0];
    if (wr_fire && hit(paddr, OFF_TRIP_ON_DLY))
      ton_d = pwdata[DLY_W-1:0];
    if (wr_fire && hit(paddr, OFF_TRIP_OFF_DLY))
      toff_d = pwdata[DLY_W-1:0];
    if (wr_fire && hit(paddr, OFF_INT_MASK))
      mask_d = pwdata[EV_W-1:0];
    if (wr_fire && hit(paddr, OFF_POLARITY))
    begin
      pol_d[NUM_BASE-1:0] = pwdata[NUM_BASE-1:0];
      // expansion bits exist only when fitted
      if (exp_s_q)
        pol_d[NUM_CH-1:NUM_BASE] = pwdata[NUM_CH-1:NUM_BASE];
    end
    for (int i = 0; i < NUM_BASE; i++)
    begin
      if (wr_fire && hit(paddr, OFF_FUNC_BASE))
        func_d[i] = pwdata[i*FUNC_STRIDE +: FUNC_W];
      if (wr_fire && hit(paddr, OFF_FUNC_EXP))
        func_d[i+NUM_BASE] = pwdata[i*FUNC_STRIDE +: FUNC_W];
    end
    ev[EV_FAULT_ON]   = fault_ind && !fault_ind_q;
    ev[EV_FAULT_OFF]  = !fault_ind && fault_ind_q;
    ev[EV_OUT_CHANGE] = ch_st_d != ch_st_q;
    // a new event wins over a write-one clear
    sts_d = sts_q;
    if (wr_fire && hit(paddr, OFF_INT_STATUS))
      sts_d = sts_q & ~pwdata[EV_W-1:0];
    sts_d = sts_d | ev;
    irq_d = |(sts_d & mask_d);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st_q        <= APB_IDLE;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= 32'h0000_0000;
      trip_mode_q <= TRIP_MODE_RST;
      gon_q       <= DLY_RST;
      goff_q      <= DLY_RST;
      ton_q       <= DLY_RST;
      toff_q      <= DLY_RST;
      pol_q       <= POLARITY_RST;
      mask_q      <= INT_MASK_RST;
      sts_q       <= '0;
      irq_q       <= 1'b0;
      fault_ind_q <= 1'b0;
      func_q[CH_FIRST_RELAY]    <= FUNC_FIRST_RELAY_RST;
      func_q[CH_OPEN_COLL] <= FUNC_OPEN_C_RST;
      func_q[CH_RELAY2]    <= FUNC_RELAY2_RST;
      for (int i = NUM_BASE; i < NUM_CH; i++)
        func_q[i] <= FUNC_EXP_RST;
    end
    else
    begin
      st_q        <= st_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      prdata_q    <= prdata_d;
      trip_mode_q <= trip_mode_d;
      gon_q       <= gon_d;
      goff_q      <= goff_d;
      ton_q       <= ton_d;
      toff_q      <= toff_d;
      pol_q       <= pol_d;
      mask_q      <= mask_d;
      sts_q       <= sts_d;
      irq_q       <= irq_d;
      fault_ind_q <= fault_ind;
      func_q      <= func_d;
    end
  end

  // delay tick, per-channel delay counters and pins
  always_comb
  begin
    logic            tgt;
    logic            is_trip;
    logic [DLY_W-1:0] dly;
    tgt     = 1'b0;
    is_trip = 1'b0;
    dly     = '0;
    tick_d     = tick_cnt_q == 32'(TICK_CYCLES - 1);
    tick_cnt_d = tick_d ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    ch_st_d    = ch_st_q;
    cnt_d      = cnt_q;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // trip function follows the fault indication
      is_trip = func_q[i] == FUNC_TRIP;
      tgt     = is_trip ? fault_ind : cond_s_q[i];
      if (i >= NUM_BASE && !exp_s_q)
        tgt = 1'b0;
      // general delays only for non-trip functions
      if (is_trip)
        dly = tgt ? ton_q : toff_q;
      else
        dly = tgt ? gon_q : goff_q;
      if (tgt == ch_st_q[i])
        cnt_d[i] = '0;
      else if (dly == '0 || (tick_q && cnt_q[i] + 16'h0001 >= dly))
      begin
        ch_st_d[i] = tgt;
        cnt_d[i]   = '0;
      end
      else if (tick_q)
        cnt_d[i] = cnt_q[i] + 16'h0001;
    end
    // polarity per channel, bit 0 first relay
    pin_d = ch_st_d ^ pol_q;
    if (!exp_s_q)
      pin_d[NUM_CH-1:NUM_BASE] = 3'h0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
      ch_st_q    <= '0;
      pin_q      <= '0;
      for (int i = 0; i < NUM_CH; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      ch_st_q    <= ch_st_d;
      pin_q      <= pin_d;
      cnt_q      <= cnt_d;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign irq                   = irq_q;
  assign first_relay           = pin_q[CH_FIRST_RELAY];
  assign open_collector_output = pin_q[CH_OPEN_COLL];
  assign second_relay          = pin_q[CH_RELAY2];
  assign exp_out               = pin_q[NUM_CH-1:NUM_BASE];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_ch1_rise_gen;
    !ch_st_q[CH_OPEN_COLL] ##1 ch_st_q[CH_OPEN_COLL] && func_q[CH_OPEN_COLL] != FUNC_TRIP;
  endsequence

  a_low_volt_ind: assert property (trip_mode_q[TM_LOW_VOLT_BIT] && trip_s_q.low_voltage
                                   && func_q[CH_FIRST_RELAY] == FUNC_TRIP && ton_q == '0
                                   |=> ch_st_q[CH_FIRST_RELAY])
    else $error("low-voltage trip not indicated");
  a_other_trip_ind: assert property (trip_s_q.other && !trip_s_q.low_voltage && !trip_s_q.restart_fail
                                     && func_q[CH_OPEN_COLL] == FUNC_TRIP && ton_q == '0 && toff_q == '0
                                     |=> ch_st_q[CH_OPEN_COLL] == $past(trip_mode_q[TM_OTHER_BIT]))
    else $error("other trip indication wrong");
  a_restart_ind: assert property (trip_mode_q[TM_RESTART_BIT] && trip_s_q.restart_fail
                                  && func_q[CH_RELAY2] == FUNC_TRIP && ton_q == '0
                                  |=> ch_st_q[CH_RELAY2])
    else $error("restart failure not indicated");
  a_trip_follow: assert property (func_q[CH_FIRST_RELAY] == FUNC_TRIP && ton_q == '0 && fault_ind
                                  |=> ch_st_q[CH_FIRST_RELAY])
    else $error("trip output did not operate");
  a_trip_on_dly: assert property ($rose(ch_st_q[CH_FIRST_RELAY]) && $past(func_q[CH_FIRST_RELAY]) == FUNC_TRIP
                                  && $past(ton_q) != '0 |-> $past(tick_q))
    else $error("trip output rose without delay tick");
  a_trip_off_clr: assert property ($fell(ch_st_q[CH_FIRST_RELAY]) && $past(func_q[CH_FIRST_RELAY]) == FUNC_TRIP
                                   |-> !$past(fault_ind))
    else $error("trip output released during trip");
  a_gen_on_dly: assert property (s_ch1_rise_gen |-> $past(cond_s_q[CH_OPEN_COLL])
                                 && ($past(gon_q) == '0 || $past(tick_q)))
    else $error("general output rose early");
  a_gen_off_dly: assert property ($fell(ch_st_q[CH_RELAY2]) && $past(func_q[CH_RELAY2]) != FUNC_TRIP
                                  |-> !$past(cond_s_q[CH_RELAY2])
                                  && ($past(goff_q) == '0 || $past(tick_q)))
    else $error("general output fell early");
  // contact level from state and polarity
  a_pol_level: assert property (##1 first_relay == (ch_st_q[CH_FIRST_RELAY] ^ $past(pol_q[CH_FIRST_RELAY])))
    else $error("relay contact polarity wrong");
  a_pol_order: assert property (##1 open_collector_output ==
                                (ch_st_q[CH_OPEN_COLL] ^ $past(pol_q[CH_OPEN_COLL])))
    else $error("collector polarity bit misplaced");
  a_exp_absent: assert property (!exp_s_q && $past(!exp_s_q) |-> exp_out == 3'h0)
    else $error("expansion output driven while absent");
  a_tick_pulse: assert property (TICK_CYCLES > 1 && tick_q |=> !tick_q)
    else $error("delay tick longer than one cycle");

endmodule

// ===== fotl_terminal_test.sv
// fotl_terminal_test: self-checking bench of the fault and output terminal block
`timescale 1ns/1ps
module fotl_terminal_test;
  import fotl_pkg::*;

  localparam int TK = 4;

  logic        sys_clk;
  logic        reset;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  fotl_trip_t  trip_in;
  logic [5:0]  cond_in;
  logic        exp_fitted;
  logic        first_relay;
  logic        open_collector_output;
  logic        second_relay;
  logic [2:0]  exp_out;
  logic        irq;
  logic [5:0]  closed;
  int          n_switch;
  int          n_fail;
  int          check_count;
  logic [31:0] rd;
  logic        err;

  fotl_terminal #(.TICK_CYCLES(TK)) dut (.sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .trip_in, .cond_in, .exp_fitted, .first_relay,
    .open_collector_output, .second_relay, .exp_out, .irq);

  fotl_load_model load (.sys_clk, .first_relay, .open_collector_output, .second_relay, .exp_out,
    .closed, .n_switch);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one apb transfer, request held until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      check("pready wait", 32'h0, 32'h1);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(what, rd, exp);
  endtask

  // contact keeps old level before n ticks, has new one after
  task automatic dly_chk(input int ch, input logic nv, input int n);
    if (n > 0)
    begin
      cyc((n - 1) * TK + 2);
      check("contact held", closed[ch], !nv);
      cyc(TK + 4);
    end
    else
      cyc(6);
    check("contact switched", closed[ch], nv);
  endtask

  task automatic t_reset();
    check("contacts at reset", closed, 32'h0);
    rdchk("trip mode", OFF_TRIP_MODE, 32'h2);
    rdchk("functions", OFF_FUNC_BASE, 32'h000e011d);
    rdchk("gen on dly", OFF_GEN_ON_DLY, 32'h0);
    rdchk("gen off dly", OFF_GEN_OFF_DLY, 32'h0);
    rdchk("trip on dly", OFF_TRIP_ON_DLY, 32'h0);
    rdchk("trip off dly", OFF_TRIP_OFF_DLY, 32'h0);
    rdchk("polarity", OFF_POLARITY, 32'h0);
    rdchk("exp functions", OFF_FUNC_EXP, 32'h0);
    rdchk("output state", OFF_OUT_STATE, 32'h0);
    rdchk("int status", OFF_INT_STATUS, 32'h0);
    rdchk("int mask", OFF_INT_MASK, 32'h0);
    rdchk("unmapped read", 8'h30, 32'h0);
    check("unmapped error", err, 32'h1);
  endtask

  task automatic t_polarity();
    wr(OFF_POLARITY, 32'h3f);
    rdchk("polarity no exp", OFF_POLARITY, 32'h07);
    cyc(3);
    check("base closed", closed, 32'h07);
    wr(OFF_POLARITY, 32'h02);
    cyc(3);
    check("collector bit", closed, 32'h02);
    @(posedge sys_clk);
    exp_fitted <= 1'b1;
    cyc(4);
    wr(OFF_POLARITY, 32'h3f);
    rdchk("polarity exp", OFF_POLARITY, 32'h3f);
    cyc(3);
    check("all closed", closed, 32'h3f);
    wr(OFF_FUNC_EXP, 32'h001c0000);
    rdchk("exp functions set", OFF_FUNC_EXP, 32'h001c0000);
    @(posedge sys_clk);
    cond_in[3] <= 1'b1;
    trip_in <= 3'b010;
    cyc(6);
    check("active nc opens", closed[3], 32'h0);
    check("exp trip opens", closed[5], 32'h0);
    @(posedge sys_clk);
    cond_in[3] <= 1'b0;
    trip_in <= '0;
    wr(OFF_POLARITY, 32'h0);
    cyc(6);
    check("all open", closed, 32'h0);
    exp_fitted <= 1'b0;
  endtask

  task automatic t_trip_mask();
    logic [2:0] m;
    @(posedge sys_clk);
    trip_in <= 3'b010;
    cyc(6);
    check("non-trip function", closed, 32'h0);
    @(posedge sys_clk);
    trip_in <= '0;
    wr(OFF_FUNC_BASE, 32'h001c1c1c);
    for (int k = 0; k < 3; k++)
      for (int j = 0; j < 2; j++)
      begin
        m = j ? (3'h1 << k) : (3'h7 ^ (3'h1 << k));
        wr(OFF_TRIP_MODE, {29'h0, m});
        @(posedge sys_clk);
        trip_in <= fotl_trip_t'(3'h1 << k);
        cyc(6);
        check("trip contacts", closed, {29'h0, {3{m[k]}}});
        rdchk("trip state", OFF_OUT_STATE, {25'h0, m[k], 3'h0, {3{m[k]}}});
        @(posedge sys_clk);
        trip_in <= '0;
        cyc(6);
        check("cleared contacts", closed, 32'h0);
      end
  endtask

  task automatic t_irq();
    wr(OFF_TRIP_MODE, 32'h7);
    wr(OFF_INT_STATUS, 32'h7);
    rdchk("status clear", OFF_INT_STATUS, 32'h0);
    @(posedge sys_clk);
    trip_in <= 3'b010;
    cyc(6);
    rdchk("status rise", OFF_INT_STATUS, 32'h5);
    check("irq masked", irq, 32'h0);
    wr(OFF_INT_MASK, 32'h1);
    cyc(2);
    check("irq raised", irq, 32'h1);
    wr(OFF_INT_STATUS, 32'h1);
    cyc(2);
    check("irq cleared", irq, 32'h0);
    @(posedge sys_clk);
    trip_in <= '0;
    cyc(6);
    rdchk("status fall", OFF_INT_STATUS, 32'h6);
    wr(OFF_INT_MASK, 32'h2);
    cyc(2);
    check("irq on fall", irq, 32'h1);
    wr(OFF_INT_STATUS, 32'h7);
    wr(OFF_INT_MASK, 32'h0);
  endtask

  task automatic t_delays();
    wr(OFF_FUNC_BASE, 32'h000e011c);
    wr(OFF_TRIP_ON_DLY, 32'h3);
    wr(OFF_TRIP_OFF_DLY, 32'h2);
    wr(OFF_GEN_ON_DLY, 32'h2);
    wr(OFF_GEN_OFF_DLY, 32'h3);
    @(posedge sys_clk);
    trip_in <= 3'b010;
    dly_chk(0, 1'b1, 3);
    @(posedge sys_clk);
    trip_in <= '0;
    dly_chk(0, 1'b0, 2);
    @(posedge sys_clk);
    cond_in[1] <= 1'b1;
    cond_in[2] <= 1'b1;
    dly_chk(1, 1'b1, 2);
    check("relay two on", closed[2], 32'h1);
    @(posedge sys_clk);
    cond_in[1] <= 1'b0;
    cond_in[2] <= 1'b0;
    dly_chk(1, 1'b0, 3);
    check("relay two off", closed[2], 32'h0);
    wr(OFF_TRIP_ON_DLY, 32'h0);
    wr(OFF_TRIP_OFF_DLY, 32'h0);
    wr(OFF_GEN_ON_DLY, 32'h8);
    wr(OFF_GEN_OFF_DLY, 32'h8);
    @(posedge sys_clk);
    trip_in <= 3'b010;
    cond_in[1] <= 1'b1;
    dly_chk(0, 1'b1, 0);
    check("collector waits", closed[1], 32'h0);
    cyc(8 * TK + 2);
    check("collector on", closed[1], 32'h1);
    @(posedge sys_clk);
    trip_in <= '0;
    cond_in[1] <= 1'b0;
    dly_chk(0, 1'b0, 0);
    cyc(8);
    @(posedge sys_clk);
    cond_in[1] <= 1'b1;
    cyc(40);
    check("off count cancelled", closed[1], 32'h1);
  endtask

  initial
  begin
    n_fail = 0;
    check_count = 0;
    reset = 1'b1;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    trip_in = '0;
    cond_in = 6'h00;
    exp_fitted = 1'b0;
    cyc(10);
    reset <= 1'b0;
    cyc(3);
    t_reset();
    t_polarity();
    t_trip_mask();
    t_irq();
    t_delays();
    check("contact movements", n_switch > 0, 32'h1);
    end_of_test();
  end
endmodule
